// >>> bcg_pkg.sv
// constants shared by the byte clock generator and its auxiliary divider
// assumes one 125 MHz system clock; the byte, symbol and stagger counts are derived from it
//
// Summary of operation
// - five 12.5 MHz byte clocks, 50% duty
// - byte clock stagger 8 ns or 16 ns
// - 25 MHz symbol clock, 40/60, falls on phases 0 and 5
// - aux clock 15.625 or 31.25 MHz by select
// - aux clock switches frequency without runt pulses
// - reference is crystal when low, external when high
// - phase comparator compares feedback against reference
// - filter monitor disabled unless its enable is set
package bcg_pkg;

    // ------------------------------------------------------------
    // clock rate and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS    = 8;
    localparam int BYTE_FREQ_KHZ    = 12500;
    localparam int SYM_FREQ_KHZ     = 25000;
    localparam int SYM_HIGH_PCT     = 40;
    localparam int STEP_LO_NS       = 8;
    localparam int STEP_HI_NS       = 16;

    localparam int BYTE_PERIOD_NS   = 1000000 / BYTE_FREQ_KHZ;
    localparam int SYM_PERIOD_NS    = 1000000 / SYM_FREQ_KHZ;
    localparam int BYTE_CYC         = BYTE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int SYM_CYC          = SYM_PERIOD_NS / CLK_PERIOD_NS;
    localparam int SYM_HIGH_CYC     = (SYM_CYC * SYM_HIGH_PCT) / 100;
    localparam int STEP_LO_CYC      = (STEP_LO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STEP_HI_CYC      = (STEP_HI_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // widths and typed constants
    // ------------------------------------------------------------
    localparam int NUM_BYTE_CLK     = 5;
    localparam int PHASE_W          = 4;
    localparam int WRAP_W           = 5;

    localparam logic [PHASE_W-1:0] PHASE_RST  = 4'h0;
    localparam logic [PHASE_W-1:0] PHASE_ONE  = 4'h1;
    localparam logic [PHASE_W-1:0] PHASE_TWO  = 4'h2;
    localparam logic [PHASE_W-1:0] PHASE_MAX  = PHASE_W'(BYTE_CYC - 1);
    localparam logic [PHASE_W-1:0] PHASE_HALF = PHASE_W'(BYTE_CYC / 2);
    localparam logic [PHASE_W-1:0] SYM_LEN    = PHASE_W'(SYM_CYC);
    localparam logic [PHASE_W-1:0] SYM_RISE   = PHASE_W'(SYM_CYC - SYM_HIGH_CYC);
    localparam logic [WRAP_W-1:0]  WRAP_LEN   = WRAP_W'(BYTE_CYC);

    // feedback age saturates one cycle short of one byte period
    localparam logic [PHASE_W-1:0] AGE_MAX    = PHASE_MAX;
    localparam logic [PHASE_W-1:0] AGE_ZERO   = 4'h0;

    // consecutive zero-error comparisons before lock is declared
    localparam logic [2:0] LOCK_GOOD  = 3'h4;
    localparam logic [2:0] GOOD_ZERO  = 3'h0;
    localparam logic [2:0] GOOD_ONE   = 3'h1;

    // auxiliary divider: bit 2 gives 15.625 MHz, bit 1 gives 31.25 MHz
    localparam int AUX_CNT_W        = 3;
    localparam int AUX_SLOW_BIT     = 2;
    localparam int AUX_FAST_BIT     = 1;
    localparam logic [AUX_CNT_W-1:0] AUX_CNT_RST = 3'h0;
    localparam logic [AUX_CNT_W-1:0] AUX_CNT_ONE = 3'h1;
    localparam logic [AUX_CNT_W-1:0] AUX_CNT_TOP = 3'h7;

    // lock state
    typedef enum logic [0:0]
    {
        LOCK_ACQ  = 1'b0,
        LOCK_HELD = 1'b1
    } bcg_lock_e;

endpackage

// >>> bcg_aux_if.sv
// signals between the generator top and its auxiliary clock divider
// assumes both ends run on the same system clock
`timescale 1ns/10ps
interface bcg_aux_if;
    logic clk_en;
    logic freq_sel;
    logic aux_clk;

    modport gen
    (
        input  clk_en,
        input  freq_sel,
        output aux_clk
    );

    modport user
    (
        output clk_en,
        output freq_sel,
        input  aux_clk
    );
endinterface

// >>> bcg_aux_divider.sv
// auxiliary clock divider with runt-free frequency change
// assumes a synchronous active-high reset and a shared clock enable
`timescale 1ns/10ps
module bcg_aux_divider
(
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    bcg_aux_if.gen    aux
);

    logic [bcg_pkg::AUX_CNT_W-1:0] cnt_reg;
    logic [bcg_pkg::AUX_CNT_W-1:0] cnt_next;
    logic                          sel_reg;
    logic                          sel_next;
    logic                          out_reg;
    logic                          out_next;

    // ------------------------------------------------------------
    // divider and select
    // ------------------------------------------------------------

    // select is taken only at the wrap, where both taps fall together
    always_comb
    begin
        cnt_next = cnt_reg + bcg_pkg::AUX_CNT_ONE;
        sel_next = sel_reg;
        if (cnt_reg == bcg_pkg::AUX_CNT_TOP)
        begin
            sel_next = aux.freq_sel;
        end
        out_next = sel_next ? cnt_next[bcg_pkg::AUX_FAST_BIT]
                            : cnt_next[bcg_pkg::AUX_SLOW_BIT];
    end

    // registers, frozen while the enable is low
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            cnt_reg <= bcg_pkg::AUX_CNT_RST;
            sel_reg <= 1'b0;
            out_reg <= 1'b0;
        end
        else if (aux.clk_en)
        begin
            cnt_reg <= cnt_next;
            sel_reg <= sel_next;
            out_reg <= out_next;
        end
    end

    assign aux.aux_clk = out_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------

    a_aux_no_runt: assert property (@(posedge clk_i) disable iff (sys_rst_i || !aux.clk_en)
        $changed(sel_reg) |-> !out_reg ##1 !out_reg)
        else $error("aux clock not low across a frequency change");

    a_aux_slow_rate: assert property (@(posedge clk_i) disable iff (sys_rst_i || !aux.clk_en)
        ($rose(out_reg) && !sel_reg && $past(sel_reg, 8) == 1'b0 && !$past(sys_rst_i, 5))
        |-> !$past(out_reg, 4) && $past(out_reg, 5))
        else $error("slow aux clock low time wrong");

    a_aux_fast_rate: assert property (@(posedge clk_i) disable iff (sys_rst_i || !aux.clk_en)
        ($rose(out_reg) && sel_reg && $past(sel_reg, 4) && !$past(sys_rst_i, 3))
        |-> !$past(out_reg, 2) && $past(out_reg, 3))
        else $error("fast aux clock low time wrong");

endmodule

// >>> bcg_byte_clock_generation.sv
// byte, symbol and auxiliary clock generation with digital phase loop
// assumes inputs synchronous to clk_i; the feedback input is looped
// back from one byte clock outside the block
`timescale 1ns/10ps
module bcg_byte_clock_generation
(
    input  wire logic                              clk_i,
    input  wire logic                              sys_rst_i,
    input  wire logic                              clk_en_i,
    input  wire logic                              crystal_input_i,
    input  wire logic                              ref_in_i,
    input  wire logic                              ref_select_i,
    input  wire logic                              loop_feedback_input_i,
    input  wire logic                              phase_offset_select_i,
    input  wire logic                              aux_clock_freq_select_i,
    input  wire logic                              filter_output_enable_i,
    output logic [bcg_pkg::NUM_BYTE_CLK-1:0]       local_byte_clock_o,
    output logic                                   local_symbol_clock_o,
    output logic                                   aux_clock_output_o,
    output logic                                   crystal_output_o,
    output logic [bcg_pkg::PHASE_W-1:0]            loop_filter_monitor_o,
    output logic                                   loop_filter_monitor_oe_o,
    output logic                                   locked_o
);

    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic                           ref_lvl_reg,  ref_lvl_next;
    logic                           ref_prev_reg, ref_prev_next;
    logic                           fbk_lvl_reg,  fbk_lvl_next;
    logic                           fbk_prev_reg, fbk_prev_next;
    logic                           step_reg,     step_next;
    logic                           xtal_reg,     xtal_next;
    logic                           ref_edge;
    logic                           fbk_edge;

    logic [bcg_pkg::PHASE_W-1:0]    phase_reg,    phase_next;
    logic [bcg_pkg::PHASE_W-1:0]    age_reg,      age_next;
    logic [bcg_pkg::PHASE_W-1:0]    err_reg,      err_next;
    logic [2:0]                     good_reg,     good_next;
    bcg_pkg::bcg_lock_e             lock_reg,     lock_next;
    logic                           mon_en_reg,   mon_en_next;
    logic [bcg_pkg::PHASE_W-1:0]    mon_reg,      mon_next;

    logic [bcg_pkg::NUM_BYTE_CLK-1:0] lbc_reg,    lbc_next;
    logic                           lsc_reg,      lsc_next;
    logic [bcg_pkg::PHASE_W-1:0]    sym_pos;

    bcg_aux_if aux_bus ();

    // ------------------------------------------------------------
    // input sampling
    // ------------------------------------------------------------

    // reference mux, edge history and static selects
    always_comb
    begin
        ref_lvl_next  = ref_select_i ? ref_in_i : crystal_input_i;
        ref_prev_next = ref_lvl_reg;
        fbk_lvl_next  = loop_feedback_input_i;
        fbk_prev_next = fbk_lvl_reg;
        step_next     = phase_offset_select_i;
        xtal_next     = ~crystal_input_i; // oscillator feedback drive
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            ref_lvl_reg  <= 1'b1; // no false edge after reset
            ref_prev_reg <= 1'b1;
            fbk_lvl_reg  <= 1'b0;
            fbk_prev_reg <= 1'b0;
            step_reg     <= 1'b0;
            xtal_reg     <= 1'b0;
        end
        else if (clk_en_i)
        begin
            ref_lvl_reg  <= ref_lvl_next;
            ref_prev_reg <= ref_prev_next;
            fbk_lvl_reg  <= fbk_lvl_next;
            fbk_prev_reg <= fbk_prev_next;
            step_reg     <= step_next;
            xtal_reg     <= xtal_next;
        end
    end

    // a shared site reference simply arrives on ref_in_i
    assign ref_edge = ref_lvl_reg & ~ref_prev_reg;
    assign fbk_edge = fbk_lvl_reg & ~fbk_prev_reg;

    // ------------------------------------------------------------
    // phase comparator and loop
    // ------------------------------------------------------------

    // feedback age at each reference edge is the phase error
    always_comb
    begin
        age_next    = fbk_edge ? bcg_pkg::AGE_ZERO
                    : (age_reg == bcg_pkg::AGE_MAX) ? age_reg
                    : age_reg + bcg_pkg::PHASE_ONE;
        err_next    = err_reg;
        good_next   = good_reg;
        lock_next   = lock_reg;
        phase_next  = (phase_reg == bcg_pkg::PHASE_MAX) ? bcg_pkg::PHASE_RST
                    : phase_reg + bcg_pkg::PHASE_ONE;
        if (ref_edge)
        begin
            err_next = fbk_edge ? bcg_pkg::AGE_ZERO : age_next;
            if (err_next == bcg_pkg::AGE_ZERO)
            begin
                if (good_reg == bcg_pkg::LOCK_GOOD)
                begin
                    lock_next = bcg_pkg::LOCK_HELD;
                end
                else
                begin
                    good_next = good_reg + bcg_pkg::GOOD_ONE;
                end
            end
            else
            begin
                good_next = bcg_pkg::GOOD_ZERO;
                lock_next = bcg_pkg::LOCK_ACQ;
                if (err_next < bcg_pkg::PHASE_HALF)
                begin
                    phase_next = phase_reg; // feedback early: stretch
                end
                else if (phase_reg >= bcg_pkg::PHASE_MAX - bcg_pkg::PHASE_ONE)
                begin
                    phase_next = phase_reg + bcg_pkg::PHASE_TWO - bcg_pkg::PHASE_MAX
                               - bcg_pkg::PHASE_ONE; // feedback late: skip
                end
                else
                begin
                    phase_next = phase_reg + bcg_pkg::PHASE_TWO;
                end
            end
        end
        mon_en_next = filter_output_enable_i;
        mon_next    = filter_output_enable_i ? err_next : bcg_pkg::AGE_ZERO;
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            phase_reg  <= bcg_pkg::PHASE_RST;
            age_reg    <= bcg_pkg::AGE_MAX;
            err_reg    <= bcg_pkg::AGE_ZERO;
            good_reg   <= bcg_pkg::GOOD_ZERO;
            lock_reg   <= bcg_pkg::LOCK_ACQ;
            mon_en_reg <= 1'b0;
            mon_reg    <= bcg_pkg::AGE_ZERO;
        end
        else if (clk_en_i)
        begin
            phase_reg  <= phase_next;
            age_reg    <= age_next;
            err_reg    <= err_next;
            good_reg   <= good_next;
            lock_reg   <= lock_next;
            mon_en_reg <= mon_en_next;
            mon_reg    <= mon_next;
        end
    end

    // ------------------------------------------------------------
    // output clock decode
    // ------------------------------------------------------------

    // each byte clock is the phase shifted back by its stagger
    for (genvar k = 0; k < bcg_pkg::NUM_BYTE_CLK; k++)
    begin : g_lbc
        logic [bcg_pkg::WRAP_W-1:0] off;
        logic [bcg_pkg::WRAP_W-1:0] sum;
        logic [bcg_pkg::WRAP_W-1:0] pos;
        assign off = step_reg ? bcg_pkg::WRAP_W'(k * bcg_pkg::STEP_HI_CYC)
                              : bcg_pkg::WRAP_W'(k * bcg_pkg::STEP_LO_CYC);
        assign sum = {1'b0, phase_next} + bcg_pkg::WRAP_LEN - off;
        assign pos = (sum >= bcg_pkg::WRAP_LEN) ? sum - bcg_pkg::WRAP_LEN : sum;
        assign lbc_next[k] = pos < {1'b0, bcg_pkg::PHASE_HALF};
    end

    // symbol clock high for the last two slots of each half byte
    always_comb
    begin
        sym_pos  = (phase_next >= bcg_pkg::SYM_LEN) ? phase_next - bcg_pkg::SYM_LEN
                                                    : phase_next;
        lsc_next = sym_pos >= bcg_pkg::SYM_RISE;
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            lbc_reg <= '0;
            lsc_reg <= 1'b0;
        end
        else if (clk_en_i)
        begin
            lbc_reg <= lbc_next;
            lsc_reg <= lsc_next;
        end
    end

    // ------------------------------------------------------------
    // auxiliary clock and outputs
    // ------------------------------------------------------------
    assign aux_bus.clk_en   = clk_en_i;
    assign aux_bus.freq_sel = aux_clock_freq_select_i;

    bcg_aux_divider u_aux
    (
        .clk_i     (clk_i),
        .sys_rst_i (sys_rst_i),
        .aux       (aux_bus.gen)
    );

    assign local_byte_clock_o       = lbc_reg;
    assign local_symbol_clock_o     = lsc_reg;
    assign aux_clock_output_o       = aux_bus.aux_clk;
    assign crystal_output_o         = xtal_reg;
    assign loop_filter_monitor_o    = mon_reg;
    assign loop_filter_monitor_oe_o = mon_en_reg;
    assign locked_o                 = (lock_reg == bcg_pkg::LOCK_HELD);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------

    a_lsc_fall_align: assert property (@(posedge clk_i) disable iff (sys_rst_i || !clk_en_i)
        $fell(lsc_reg) |-> $changed(lbc_reg[0]))
        else $error("symbol clock fell away from a byte clock edge");

    a_lsc_duty_cycle: assert property (@(posedge clk_i) disable iff (sys_rst_i || !clk_en_i)
        (locked_o && $fell(lsc_reg)) |-> $past(lsc_reg, 2) && !$past(lsc_reg, 3)
        && !$past(lsc_reg, 5) && $past(lsc_reg, 6))
        else $error("symbol clock duty cycle wrong");

    a_byte_duty_cycle: assert property (@(posedge clk_i) disable iff (sys_rst_i || !clk_en_i)
        (locked_o && $rose(lbc_reg[0])) |-> !$past(lbc_reg[0], 5) && $past(lbc_reg[0], 6))
        else $error("byte clock low time wrong");

    a_byte_stagger_lo: assert property (@(posedge clk_i) disable iff (sys_rst_i || !clk_en_i)
        (locked_o && !step_reg && !$past(step_reg, 2)) |-> lbc_reg[4:1] == $past(lbc_reg[3:0]))
        else $error("byte clocks not one cycle apart");

    a_byte_stagger_hi: assert property (@(posedge clk_i) disable iff (sys_rst_i || !clk_en_i)
        (locked_o && step_reg && $past(step_reg, 3))
        |-> lbc_reg[4:1] == $past(lbc_reg[3:0], 2))
        else $error("byte clocks not two cycles apart");

    a_ref_source_sel: assert property (@(posedge clk_i) disable iff (sys_rst_i || !clk_en_i)
        (ref_edge && $past(ref_select_i) == $past(ref_select_i, 2))
        |-> ($past(ref_select_i) ? $past(ref_in_i) && !$past(ref_in_i, 2)
                                 : $past(crystal_input_i) && !$past(crystal_input_i, 2)))
        else $error("reference edge from unselected source");

    a_loop_early_hold: assert property (@(posedge clk_i) disable iff (sys_rst_i || !clk_en_i)
        (ref_edge && !fbk_edge && age_next != bcg_pkg::AGE_ZERO
         && age_next < bcg_pkg::PHASE_HALF) |=> phase_reg == $past(phase_reg) && !locked_o)
        else $error("early feedback did not stretch the phase");

    a_filter_mon_off: assert property (@(posedge clk_i) disable iff (sys_rst_i || !clk_en_i)
        !$past(filter_output_enable_i) |-> !loop_filter_monitor_oe_o
        && loop_filter_monitor_o == bcg_pkg::AGE_ZERO)
        else $error("filter monitor active while disabled");

endmodule

// >>> bcg_ref_osc.sv
// reference oscillator model standing outside the byte clock generator
// assumes the bench clock at 125 MHz; lines change on the falling edge
`timescale 1ns/10ps
module bcg_ref_osc
(
    input  wire logic       clk_i,
    input  wire logic       xtal_run_i,
    input  wire logic       ext_run_i,
    input  wire logic [3:0] skew_i,
    output logic            crystal_o,
    output logic            ref_o
);
    logic [3:0] cnt_reg = 4'h0;
    logic [3:0] cnt_next;
    logic [4:0] sum;
    logic [4:0] ext_cnt;

    // ---------------------------------------------------------
    // ten-cycle count, 12.5 MHz at the bench clock
    // ---------------------------------------------------------
    always_comb
    begin
        cnt_next = (cnt_reg == 4'h9) ? 4'h0 : cnt_reg + 4'h1;
        sum      = {1'b0, cnt_reg} + {1'b0, skew_i};
        ext_cnt  = (sum >= 5'h0A) ? sum - 5'h0A : sum;
    end

    // stepped on the falling edge, away from the sampling edge
    always @(negedge clk_i)
        cnt_reg <= cnt_next;

    // a stopped oscillator line rests low, like a grounded unused input
    assign crystal_o = xtal_run_i & (cnt_reg < 4'h5);
    assign ref_o     = ext_run_i & (ext_cnt < 5'h05);
endmodule

// >>> testbench.sv
// self-checking bench for the byte clock generator
// assumes the package, the aux interface and the design compile first
`timescale 1ns/10ps
module testbench;
    // ---------------------------------------------------------
    // signals and bookkeeping
    // ---------------------------------------------------------
    typedef struct {int kind; int src; logic [31:0] val;} bcg_note_s;
    localparam int K_HI = 0, K_PER = 1, K_LAG = 2, K_FALL = 3, K_LVL = 4, K_RUNT = 5;
    logic                               clk_i = 1'b0;
    logic                               sys_rst_i = 1'b1;
    logic                               ref_select_i = 1'b0;
    logic                               phase_offset_select_i = 1'b0;
    logic                               aux_clock_freq_select_i = 1'b0;
    logic                               filter_output_enable_i = 1'b0;
    logic                               xtal_run = 1'b1;
    logic                               ext_run = 1'b0;
    logic [3:0]                         ext_skew = 4'h0;
    wire logic                          crystal_input_i;
    wire logic                          ref_in_i;
    wire logic                          loop_feedback_input_i;
    wire logic [4:0]                    local_byte_clock_o;
    wire logic                          local_symbol_clock_o;
    wire logic                          aux_clock_output_o;
    wire logic                          crystal_output_o;
    wire logic [bcg_pkg::PHASE_W-1:0]   loop_filter_monitor_o;
    wire logic                          loop_filter_monitor_oe_o;
    wire logic                          locked_o;
    bcg_note_s                          note_q[$];
    event                               note_ev;
    int                                 n_sent = 0;
    int                                 n_done = 0;
    int                                 n_mismatch = 0;
    int                                 n_checks = 0;

    always #4 clk_i = ~clk_i;
    assign loop_feedback_input_i = local_byte_clock_o[0];

    bcg_ref_osc i_ref
    (
        .clk_i      (clk_i),
        .xtal_run_i (xtal_run),
        .ext_run_i  (ext_run),
        .skew_i     (ext_skew),
        .crystal_o  (crystal_input_i),
        .ref_o      (ref_in_i)
    );

    bcg_byte_clock_generation i_dut
    (
        .clk_i                    (clk_i),
        .sys_rst_i                (sys_rst_i),
        .clk_en_i                 (1'b1),
        .crystal_input_i          (crystal_input_i),
        .ref_in_i                 (ref_in_i),
        .ref_select_i             (ref_select_i),
        .loop_feedback_input_i    (loop_feedback_input_i),
        .phase_offset_select_i    (phase_offset_select_i),
        .aux_clock_freq_select_i  (aux_clock_freq_select_i),
        .filter_output_enable_i   (filter_output_enable_i),
        .local_byte_clock_o       (local_byte_clock_o),
        .local_symbol_clock_o     (local_symbol_clock_o),
        .aux_clock_output_o       (aux_clock_output_o),
        .crystal_output_o         (crystal_output_o),
        .loop_filter_monitor_o    (loop_filter_monitor_o),
        .loop_filter_monitor_oe_o (loop_filter_monitor_oe_o),
        .locked_o                 (locked_o)
    );

    // ---------------------------------------------------------
    // result watcher: measures outputs against the oldest note
    // ---------------------------------------------------------
    function automatic logic pick(int src);
        logic [6:0] all;
        all = {aux_clock_output_o, local_symbol_clock_o, local_byte_clock_o};
        return all[src];
    endfunction

    // step samples until the line shows a level; n counts the steps
    task automatic reach(int src, logic lvl, inout int n);
        int g;
        g = 0;
        while (pick(src) !== lvl && g < 40)
        begin
            @(negedge clk_i);
            n++;
            g++;
        end
    endtask

    always @(note_ev)
    begin : watch
        bcg_note_s   nt;
        int          hi;
        int          lo;
        logic [31:0] got;
        logic        prev;
        nt = note_q.pop_front();
        hi = 0;
        lo = 0;
        got = 32'h0;
        case (nt.kind)
            K_HI, K_PER:
            begin
                reach(nt.src, 1'b1, lo);
                reach(nt.src, 1'b0, lo);
                reach(nt.src, 1'b1, lo);
                lo = 0;
                reach(nt.src, 1'b0, hi);
                reach(nt.src, 1'b1, lo);
                got = (nt.kind == K_HI) ? hi : hi + lo;
            end
            K_LAG:
            begin
                reach(0, 1'b0, lo);
                reach(0, 1'b1, lo);
                reach(nt.src, 1'b0, hi);
                reach(nt.src, 1'b1, hi);
                got = hi;
            end
            K_FALL:
            begin
                reach(5, 1'b1, lo);
                prev = local_byte_clock_o[0];
                while (local_symbol_clock_o === 1'b1 && lo < 80)
                begin
                    prev = local_byte_clock_o[0];
                    @(negedge clk_i);
                    lo++;
                end
                got = {31'h0, local_byte_clock_o[0] ^ prev};
            end
            K_RUNT:
            begin
                // the first, partial run is not judged
                prev = pick(6);
                hi = -1;
                repeat (24)
                begin
                    @(negedge clk_i);
                    if (pick(6) !== prev)
                    begin
                        got = got + ((hi > 0 && hi < 2) ? 32'h1 : 32'h0);
                        hi = 1;
                    end
                    else if (hi > 0)
                        hi++;
                    prev = pick(6);
                end
            end
            default:
            begin
                case (nt.src)
                    0: got = {31'h0, locked_o};
                    1: got = {31'h0, loop_filter_monitor_oe_o};
                    2: got = {28'h0, loop_filter_monitor_o};
                    default: got = {18'h0, local_byte_clock_o, local_symbol_clock_o,
                        aux_clock_output_o, crystal_output_o, loop_filter_monitor_o,
                        loop_filter_monitor_oe_o, locked_o};
                endcase
            end
        endcase
        n_checks++;
        if (got !== nt.val)
        begin
            n_mismatch++;
            $display("ERROR t=%0t kind %0d src %0d got %0d want %0d",
                $time, nt.kind, nt.src, got, nt.val);
        end
        n_done++;
    end

    // ---------------------------------------------------------
    // driver tasks
    // ---------------------------------------------------------
    task automatic expect_res(int kind, int src, logic [31:0] val);
        note_q.push_back('{kind, src, val});
        n_sent++;
        -> note_ev;
        wait (n_done == n_sent);
    endtask

    task automatic relock();
        int n;
        n = 0;
        @(negedge clk_i);
        sys_rst_i = 1'b1;
        repeat (2) @(negedge clk_i);
        sys_rst_i = 1'b0;
        while (locked_o !== 1'b1 && n < 600)
        begin
            @(negedge clk_i);
            n++;
        end
    endtask

    task automatic end_test(string s);
        $display("test %s done", s);
    endtask

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ---------------------------------------------------------
    // test sequence
    // ---------------------------------------------------------
    initial
    begin : main
        int r;
        r = $urandom(32'hB9523FA7);
        repeat (2) @(negedge clk_i);
        expect_res(K_LVL, 3, 0);
        sys_rst_i = 1'b0;
        end_test("reset");
        filter_output_enable_i = 1'b1;
        relock();
        expect_res(K_LVL, 0, 1);
        for (int k = 0; k < 5; k++)
        begin
            expect_res(K_HI, k, 5);
            expect_res(K_PER, k, 10);
            if (k > 0)
                expect_res(K_LAG, k, k);
        end
        expect_res(K_HI, 5, 2);
        expect_res(K_PER, 5, 5);
        expect_res(K_FALL, 5, 1);
        expect_res(K_LVL, 1, 1);
        expect_res(K_LVL, 2, 0);
        filter_output_enable_i = 1'b0;
        repeat (2) @(negedge clk_i);
        expect_res(K_LVL, 1, 0);
        expect_res(K_LVL, 2, 0);
        end_test("crystal lock");
        repeat (6)
        begin
            repeat ($urandom_range(7, 0)) @(negedge clk_i);
            aux_clock_freq_select_i = ~aux_clock_freq_select_i;
            expect_res(K_RUNT, 6, 0);
            expect_res(K_HI, 6, aux_clock_freq_select_i ? 2 : 4);
            expect_res(K_PER, 6, aux_clock_freq_select_i ? 4 : 8);
        end
        end_test("aux switch");
        phase_offset_select_i = 1'b1;
        relock();
        expect_res(K_LVL, 0, 1);
        for (int k = 1; k < 5; k++)
            expect_res(K_LAG, k, 2 * k);
        expect_res(K_HI, 4, 5);
        end_test("wide stagger");
        ref_select_i = 1'b1;
        ext_run = 1'b1;
        xtal_run = 1'b0;
        ext_skew = 4'($urandom_range(9, 0));
        relock();
        expect_res(K_LVL, 0, 1);
        expect_res(K_FALL, 5, 1);
        ext_run = 1'b0;
        xtal_run = 1'b1;
        relock();
        expect_res(K_LVL, 0, 0);
        end_test("reference select");
        report_and_stop();
    end

    // cuts a hang short well past the expected run length
    initial
    begin
        #(30000 * 8);
        n_mismatch++;
        report_and_stop();
    end
endmodule
